// ---- shared/dsio_pkg.sv ----
package dsio_pkg;
  // Wishbone register byte offsets
  localparam logic [4:0] ADDR_CTRL = 5'h00;
  localparam logic [4:0] ADDR_WLVL = 5'h04;
  localparam logic [4:0] ADDR_ISI_A = 5'h08;
  localparam logic [4:0] ADDR_ISI_B = 5'h0c;
  localparam logic [4:0] ADDR_STATUS = 5'h10;
  // Field positions and reset values
  localparam int CTRL_X2_BIT = 0;
  localparam int WLVL_INV_BIT = 7;
  localparam int ISI_A_COUNT = 10;
  localparam logic [7:0] WLVL_RESET = 8'h00;
  localparam logic [2:0] ISI_RESET = 3'h0;
  // Group sizes and delay line depths
  localparam int NUM_DQ = 12;
  localparam int NUM_FANOUT = 11;
  localparam int RD_LINE = 128;
  localparam int WR_LINE = 256;
  localparam logic [1:0] GEAR_PHASE_A_RISE = 2'h0;

  // Preamble and polarity tracker
  typedef enum logic [1:0] {
    DSIO_IDLE = 2'b00,
    DSIO_ARM = 2'b01,
    DSIO_PRE = 2'b10
  } dsio_rd_state_t;

  // Software settings
  typedef struct packed {
    logic x2_gearing_mode;
    logic [7:0] write_level_delay;
    logic [NUM_DQ-1:0][2:0] isi_amt;
  } dsio_cfg_t;

  // Whole state of the block
  typedef struct packed {
    dsio_cfg_t cfg;
    logic ack;
    logic [31:0] rdata;
    logic [1:0] gear_cnt;
    logic gear_a;
    logic gear_b;
    logic oe_sdr;
    logic oe_x2;
    logic pad_oe;
    logic [2:0] strb_sync;
    logic [1:0] drv_sync;
    logic [RD_LINE-1:0] rd_line;
    logic [WR_LINE-1:0] wr_line;
    logic [NUM_FANOUT-1:0] shifted_read_strobe;
    logic write_strobe_clk;
    logic preamble_detect;
    dsio_rd_state_t rd_state;
    logic capture_clk_polarity;
    logic gearbox_latch_enable;
    logic [NUM_DQ-1:0] dq_prev1;
    logic [NUM_DQ-1:0] dq_prev2;
    logic [NUM_DQ-1:0][2:0] stretch_cnt;
    logic [NUM_DQ-1:0] stretch_val;
    logic [NUM_DQ-1:0] dq_out;
  } dsio_state_t;
endpackage : dsio_pkg

// ---- rtl/dsio_strobe_ctrl.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// [R01] Outside x2 gearing, one flop on the core enable drives the pad enable.
// [R02] In x2 gearing a second flop, stepped by the gear phases, drives the enable.
// [R03] Pattern stretching acts only in x2 gearing mode.
// [R04] Every output of the twelve-pin group owns its own stretch setting.
// [R05] Long runs of equal bits get no extension.
// [R06] A lone one between zeros is lengthened.
// [R07] A lone zero between ones is lengthened.
// [R08] A three-bit setting chooses the stretch amount.
// [R09] The delay loop hands over a seven-bit calibration code.
// [R10] Left loop serves banks 0, 7, 6; right loop serves banks 1, 2, 3.
// [R11] Read strobe is delayed by the loop code and fanned to eleven pads.
// [R12] A polarity signal picks the edge for the synchronising registers.
// [R13] In x2 read mode a latch enable moves data to the second register set.
// [R14] Two gear clock phases drive data gearing and the strobe output register.
// [R15] Write leveling adds the low seven setting bits to the loop code.
// [R16] Top setting bit inverts the write strobe clock.
// [R17] The fabric controller chooses leveling values; this block just applies them.
// [R18] Capture polarity is chosen afresh at the start of every read.
// [R19] The memory leaves the strobe floating, then drives it low for the preamble.
// [R20] The first rising strobe edge after the preamble sets the polarity.
// [R21] Polarity and latch enable together adjust read capture timing.
// [R22] Preamble detect follows the raw strobe and reads high while it floats; here it follows the strobe after the two-flop synchroniser.
// [R23] Polarity and latch hold between reads until a new preamble edge.
module dsio_strobe_ctrl (
  // System clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Delay loop and core controls
  input wire logic [6:0] dll_delay_code_i,
  input wire logic core_output_enable_in_i,
  input wire logic read_i,
  input wire logic [dsio_pkg::NUM_DQ-1:0] dq_data_i,
  // Strobe pad
  input wire logic strobe_pad_i,
  input wire logic strobe_driven_i,
  // Pad side outputs
  output logic pad_oe_o,
  output logic [dsio_pkg::NUM_DQ-1:0] dq_data_o,
  output logic gear_clk_phase_a_o,
  output logic gear_clk_phase_b_o,
  output logic write_strobe_clk_o,
  output logic [dsio_pkg::NUM_FANOUT-1:0] shifted_read_strobe_o,
  output logic preamble_detect_o,
  output logic capture_clk_polarity_o,
  output logic gearbox_latch_enable_o
);

  dsio_pkg::dsio_state_t s_q;
  dsio_pkg::dsio_state_t s_d;
  logic strb_s;
  logic strb_rise;
  logic wr_sel;
  logic rd_sel;
  logic [7:0] wr_index;

  // Byte-lane merge for a register write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction : merge

  // Detects a lone bit, one-zero-one or zero-one-zero, across three samples
  function automatic logic lone_bit(input logic p2, input logic p1, input logic cur);
    return (p2 == cur) && (p1 != cur);
  endfunction : lone_bit

  // Only the second synchroniser stage and later feed logic
  assign strb_s = s_q.strb_sync[1];
  assign strb_rise = s_q.strb_sync[1] && !s_q.strb_sync[2];
  assign wr_sel = wb_cyc_i && wb_stb_i && wb_we_i && !s_q.ack;
  assign rd_sel = wb_cyc_i && wb_stb_i && !wb_we_i && !s_q.ack;
  // Write strobe delay is loop code plus leveling steps; 8 bits hold the sum
  assign wr_index = {1'b0, dll_delay_code_i} + {1'b0, s_q.cfg.write_level_delay[6:0]}; // R15

  // Next-state logic
  always_comb begin
    logic [31:0] isi_a;
    logic [31:0] isi_b;
    logic [31:0] w;
    s_d = s_q;
    isi_a = '0;
    isi_b = '0;
    w = '0;
    for (int i = 0; i < dsio_pkg::ISI_A_COUNT; i++) begin
      isi_a[3*i +: 3] = s_q.cfg.isi_amt[i];
    end
    for (int i = dsio_pkg::ISI_A_COUNT; i < dsio_pkg::NUM_DQ; i++) begin
      isi_b[3*(i-dsio_pkg::ISI_A_COUNT) +: 3] = s_q.cfg.isi_amt[i];
    end

    // Bus: answer one cycle after the request, drop ack the cycle after
    s_d.ack = wb_cyc_i && wb_stb_i && !s_q.ack;
    s_d.rdata = '0;
    if (rd_sel) begin
      case (wb_adr_i)
        dsio_pkg::ADDR_CTRL: s_d.rdata = {31'h0, s_q.cfg.x2_gearing_mode};
        dsio_pkg::ADDR_WLVL: s_d.rdata = {24'h0, s_q.cfg.write_level_delay};
        dsio_pkg::ADDR_ISI_A: s_d.rdata = isi_a;
        dsio_pkg::ADDR_ISI_B: s_d.rdata = isi_b;
        dsio_pkg::ADDR_STATUS: s_d.rdata = {16'h0, 1'b0, dll_delay_code_i, 2'h0,
                                            s_q.rd_state, s_q.preamble_detect,
                                            s_q.gearbox_latch_enable,
                                            s_q.capture_clk_polarity, strb_s};
        default: s_d.rdata = '0;
      endcase
    end
    // Leveling values come from the fabric controller and are applied as given
    if (wr_sel) begin
      case (wb_adr_i)
        dsio_pkg::ADDR_CTRL: begin
          w = merge({31'h0, s_q.cfg.x2_gearing_mode}, wb_dat_i, wb_sel_i);
          s_d.cfg.x2_gearing_mode = w[dsio_pkg::CTRL_X2_BIT];
        end
        dsio_pkg::ADDR_WLVL: begin
          w = merge({24'h0, s_q.cfg.write_level_delay}, wb_dat_i, wb_sel_i);
          s_d.cfg.write_level_delay = w[7:0]; // R17
        end
        dsio_pkg::ADDR_ISI_A: begin
          w = merge(isi_a, wb_dat_i, wb_sel_i);
          for (int i = 0; i < dsio_pkg::ISI_A_COUNT; i++) begin
            s_d.cfg.isi_amt[i] = w[3*i +: 3]; // R04
          end
        end
        dsio_pkg::ADDR_ISI_B: begin
          w = merge(isi_b, wb_dat_i, wb_sel_i);
          for (int i = dsio_pkg::ISI_A_COUNT; i < dsio_pkg::NUM_DQ; i++) begin
            s_d.cfg.isi_amt[i] = w[3*(i-dsio_pkg::ISI_A_COUNT) +: 3]; // R04
          end
        end
        default: ;
      endcase
    end

    // Gear phases a quarter cycle of the gear period apart
    s_d.gear_cnt = s_q.gear_cnt + 2'h1;
    s_d.gear_a = s_d.gear_cnt[1]; // R14
    s_d.gear_b = s_d.gear_cnt[1] ^ s_d.gear_cnt[0]; // R14

    // Tristate path: first flop always, second stepped on phase b rise, as the gear count leaves 0
    s_d.oe_sdr = core_output_enable_in_i; // R01
    if (s_q.gear_cnt == dsio_pkg::GEAR_PHASE_A_RISE) begin
      s_d.oe_x2 = s_q.oe_sdr; // R02
    end
    s_d.pad_oe = s_q.cfg.x2_gearing_mode ? s_d.oe_x2 : s_d.oe_sdr; // R01 R02

    // Pad inputs pass two flops before use
    s_d.strb_sync = {s_q.strb_sync[1:0], strobe_pad_i};
    s_d.drv_sync = {s_q.drv_sync[0], strobe_driven_i};
    s_d.preamble_detect = !s_q.drv_sync[1] || strb_s; // R22

    // Read strobe delayed by the loop code, fanned out to the pads
    s_d.rd_line = {s_q.rd_line[dsio_pkg::RD_LINE-2:0], strb_s};
    // One group here, so the code comes from whichever side loop serves its bank
    s_d.shifted_read_strobe = {dsio_pkg::NUM_FANOUT{s_q.rd_line[dll_delay_code_i]}}; // R09 R10 R11

    // Write strobe: gear phase a delayed, optionally inverted
    s_d.wr_line = {s_q.wr_line[dsio_pkg::WR_LINE-2:0], s_q.gear_a};
    s_d.write_strobe_clk = s_q.wr_line[wr_index] ^
                           s_q.cfg.write_level_delay[dsio_pkg::WLVL_INV_BIT]; // R15 R16

    // Polarity tracker: re-armed by every read, updated only on a new edge
    case (s_q.rd_state)
      dsio_pkg::DSIO_IDLE: begin
        if (read_i) begin
          s_d.rd_state = dsio_pkg::DSIO_ARM; // R18
        end
      end
      dsio_pkg::DSIO_ARM: begin
        if (s_q.drv_sync[1] && !strb_s) begin
          s_d.rd_state = dsio_pkg::DSIO_PRE; // R20
        end
      end
      dsio_pkg::DSIO_PRE: begin
        if (strb_rise) begin
          s_d.rd_state = dsio_pkg::DSIO_IDLE;
          s_d.capture_clk_polarity = s_q.gear_cnt[1]; // R12 R20 R21 R23
          s_d.gearbox_latch_enable = s_q.cfg.x2_gearing_mode && s_q.gear_cnt[0]; // R13 R21
        end
      end
      default: s_d.rd_state = dsio_pkg::DSIO_IDLE;
    endcase

    // Pattern stretching per output, only in x2 gearing
    s_d.dq_prev1 = dq_data_i;
    s_d.dq_prev2 = s_q.dq_prev1;
    for (int i = 0; i < dsio_pkg::NUM_DQ; i++) begin
      if (s_q.stretch_cnt[i] != 3'h0) begin
        s_d.stretch_cnt[i] = s_q.stretch_cnt[i] - 3'h1;
        s_d.dq_out[i] = s_q.stretch_val[i]; // R06 R07
      end else if (s_q.cfg.x2_gearing_mode && s_q.cfg.isi_amt[i] != 3'h0 &&
                   lone_bit(s_q.dq_prev2[i], s_q.dq_prev1[i], dq_data_i[i])) begin
        s_d.stretch_cnt[i] = s_q.cfg.isi_amt[i] - 3'h1; // R03 R08
        s_d.stretch_val[i] = s_q.dq_prev1[i];
        s_d.dq_out[i] = s_q.dq_prev1[i]; // R06 R07
      end else begin
        s_d.dq_out[i] = dq_data_i[i]; // R05
      end
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
      s_q.cfg.write_level_delay <= dsio_pkg::WLVL_RESET;
      s_q.rd_state <= dsio_pkg::DSIO_IDLE;
      s_q.preamble_detect <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Every output straight from a flop
  assign wb_dat_o = s_q.rdata;
  assign wb_ack_o = s_q.ack;
  assign pad_oe_o = s_q.pad_oe;
  assign dq_data_o = s_q.dq_out;
  assign gear_clk_phase_a_o = s_q.gear_a;
  assign gear_clk_phase_b_o = s_q.gear_b;
  assign write_strobe_clk_o = s_q.write_strobe_clk;
  assign shifted_read_strobe_o = s_q.shifted_read_strobe;
  assign preamble_detect_o = s_q.preamble_detect;
  assign capture_clk_polarity_o = s_q.capture_clk_polarity;
  assign gearbox_latch_enable_o = s_q.gearbox_latch_enable;

  // Checks on the tristate path
  sdr_oe_path_a: assert property (@(posedge clk_i) disable iff (rst_i) // R01
    !s_q.cfg.x2_gearing_mode && $past(!s_q.cfg.x2_gearing_mode) |->
    pad_oe_o == $past(core_output_enable_in_i))
    else $error("Pad enable does not follow core enable by one cycle");
  x2_oe_step_a: assert property (@(posedge clk_i) disable iff (rst_i) // R02
    s_q.cfg.x2_gearing_mode && $past(s_q.cfg.x2_gearing_mode) &&
    $past(s_q.cfg.x2_gearing_mode, 2) &&
    $past(s_q.gear_cnt) != dsio_pkg::GEAR_PHASE_A_RISE |-> $stable(pad_oe_o))
    else $error("Pad enable moved between gear steps");

  // Checks on the gear phases
  gear_phase_b_a: assert property (@(posedge clk_i) disable iff (rst_i) // R14
    $rose(gear_clk_phase_a_o) |-> gear_clk_phase_b_o ##1 !gear_clk_phase_b_o ##2
    gear_clk_phase_b_o)
    else $error("Gear phase b not a quarter ahead of phase a");

  // Checks on stretching
  no_stretch_sdr_a: assert property (@(posedge clk_i) disable iff (rst_i) // R03
    !s_q.cfg.x2_gearing_mode && s_q.stretch_cnt == '0 |=>
    dq_data_o == $past(dq_data_i))
    else $error("Stretching active outside x2 gearing");
  long_run_a: assert property (@(posedge clk_i) disable iff (rst_i) // R05
    s_q.stretch_cnt[0] == 3'h0 && dq_data_i[0] == s_q.dq_prev1[0] |=>
    dq_data_o[0] == $past(dq_data_i[0]))
    else $error("Extension added on a run of equal bits");
  lone_one_a: assert property (@(posedge clk_i) disable iff (rst_i) // R06 R08
    s_q.cfg.x2_gearing_mode && s_q.stretch_cnt[0] == 3'h0 &&
    s_q.cfg.isi_amt[0] >= 3'h2 && !s_q.dq_prev2[0] && s_q.dq_prev1[0] && !dq_data_i[0]
    |=> dq_data_o[0] ##1 dq_data_o[0])
    else $error("Lone one not stretched by two cycles");
  lone_zero_a: assert property (@(posedge clk_i) disable iff (rst_i) // R07
    s_q.cfg.x2_gearing_mode && s_q.stretch_cnt[2] == 3'h0 && s_q.cfg.isi_amt[2] != 3'h0 &&
    s_q.dq_prev2[2] && !s_q.dq_prev1[2] && dq_data_i[2] |=> !dq_data_o[2])
    else $error("Lone zero not stretched");

  // Checks on the read strobe and polarity tracker
  sequence preamble_seen;
    s_q.rd_state == dsio_pkg::DSIO_PRE ##0 strb_rise;
  endsequence
  polarity_load_a: assert property (@(posedge clk_i) disable iff (rst_i) // R20
    preamble_seen |=> capture_clk_polarity_o == $past(s_q.gear_cnt[1]) &&
    s_q.rd_state == dsio_pkg::DSIO_IDLE)
    else $error("Polarity not taken at preamble rising edge");
  polarity_hold_a: assert property (@(posedge clk_i) disable iff (rst_i) // R23
    !(s_q.rd_state == dsio_pkg::DSIO_PRE && strb_rise) |=>
    $stable(capture_clk_polarity_o) && $stable(gearbox_latch_enable_o))
    else $error("Polarity changed without a preamble edge");
  read_rearm_a: assert property (@(posedge clk_i) disable iff (rst_i) // R18
    s_q.rd_state == dsio_pkg::DSIO_IDLE && read_i |=> s_q.rd_state == dsio_pkg::DSIO_ARM)
    else $error("Read did not re-arm polarity selection");
  preamble_float_a: assert property (@(posedge clk_i) disable iff (rst_i) // R22
    !s_q.drv_sync[1] |=> preamble_detect_o)
    else $error("Preamble detect low while strobe floats");
  read_shift_a: assert property (@(posedge clk_i) disable iff (rst_i) // R11
    $stable(dll_delay_code_i) |=> shifted_read_strobe_o[0] ==
    $past(s_q.rd_line[dll_delay_code_i]))
    else $error("Shifted read strobe wrong tap");
endmodule : dsio_strobe_ctrl

// ---- test/dsio_mem_model.sv ----
`timescale 1ns/1ps
module dsio_mem_model (
  // Strobe pin as seen from the memory
  output logic strobe_o,
  output logic driven_o
);
  // Released strobe sits high through termination; no clock between frames
  initial begin
    strobe_o = 1'b1;
    driven_o = 1'b0;
  end

  // One read burst: float, drive low for the preamble, toggle at 400 ns, release
  task automatic burst(input int n);
    #17;
    driven_o = 1'b1;
    strobe_o = 1'b0;
    #800;
    repeat (n) begin
      strobe_o = 1'b1;
      #200;
      strobe_o = 1'b0;
      #200;
    end
    // Released line falls back to the pulled-up level, never the last value
    driven_o = 1'b0;
    strobe_o = 1'b1;
  endtask : burst
endmodule : dsio_mem_model

// ---- test/dsio_strobe_ctrl_test.sv ----
`timescale 1ns/1ps
module dsio_strobe_ctrl_test;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic core_oe = 1'b0;
  logic rd = 1'b0;
  logic [4:0] adr = 5'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] wbo;
  logic [6:0] code = 7'h03;
  logic [11:0] dq = 12'h000;
  logic [11:0] dqo;
  logic [10:0] srs;
  logic pad_oe, pa, pb, wsc, pd, pol, lat, ack, strb, drv;
  logic [11:0] pat [12] = '{12'h004, 12'h004, 12'h003, 12'h00c, 12'h00c, 12'h00c,
                            12'h00c, 12'h004, 12'h004, 12'h004, 12'h004, 12'h004};
  logic [7:0] wls [4] = '{8'h01, 8'h80, 8'h81, 8'h00};
  logic [6:0] codes [4] = '{7'h03, 7'h03, 7'h03, 7'h04};
  int offs [4] = '{1, 2, 3, 1};
  int n_fail = 0;
  int n_compared = 0;

  // System clock, 50 ns
  initial forever #25 clk_i = ~clk_i;

  dsio_mem_model mem (.strobe_o(strb), .driven_o(drv));

  // Strobe is tied to cycle: classic master raises both together
  dsio_strobe_ctrl uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(wbo),
    .wb_ack_o(ack), .dll_delay_code_i(code), .core_output_enable_in_i(core_oe),
    .read_i(rd), .dq_data_i(dq), .strobe_pad_i(strb), .strobe_driven_i(drv),
    .pad_oe_o(pad_oe), .dq_data_o(dqo), .gear_clk_phase_a_o(pa), .gear_clk_phase_b_o(pb),
    .write_strobe_clk_o(wsc), .shifted_read_strobe_o(srs), .preamble_detect_o(pd),
    .capture_clk_polarity_o(pol), .gearbox_latch_enable_o(lat));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (e !== g) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One classic cycle; ack and read data are taken at the same edge
  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    for (i = 0; i < 20 && ack !== 1'b1; i++) @(posedge clk_i);
    chk("wb ack", 1'b1, ack);
    rdat = wbo;
    cyc <= 1'b0;
  endtask : wb

  task automatic wrap_up;
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up

  task automatic t_regs;
    wb(1'b0, dsio_pkg::ADDR_WLVL, 32'h0);
    chk("wlvl reset", {24'h0, dsio_pkg::WLVL_RESET}, rdat);
    wb(1'b0, dsio_pkg::ADDR_ISI_A, 32'h0);
    chk("isi reset", 32'h0, rdat);
    wb(1'b1, 5'h14, 32'hffffffff);
    wb(1'b0, 5'h14, 32'h0);
    chk("unmapped", 32'h0, rdat);
    wb(1'b0, dsio_pkg::ADDR_STATUS, 32'h0);
    chk("code", code, rdat[14:8]);
  endtask : t_regs

  task automatic t_oe_sdr;
    @(posedge clk_i);
    core_oe <= 1'b1;
    @(negedge clk_i);
    chk("oe early", 1'b0, pad_oe);
    // A single flop: the enable shows one edge after the core raised it
    @(negedge clk_i);
    chk("oe sdr", 1'b1, pad_oe);
  endtask : t_oe_sdr

  // Bit 0 lone one, bit 1 lone one unstretched, bit 2 lone zero, bit 3 long runs
  task automatic t_isi(input logic x2, input int n);
    int k;
    int c [4];
    c = '{0, 0, 0, 0};
    wb(1'b1, dsio_pkg::ADDR_CTRL, {31'h0, x2});
    wb(1'b1, dsio_pkg::ADDR_ISI_A, 32'h000006c3);
    @(posedge clk_i);
    dq <= 12'h004;
    repeat (6) @(posedge clk_i);
    for (k = 0; k < 20; k++) begin
      dq <= (k < 12) ? pat[k] : 12'h004;
      @(negedge clk_i);
      c[0] += dqo[0];
      c[1] += dqo[1];
      c[2] += !dqo[2];
      c[3] += dqo[3];
      @(posedge clk_i);
    end
    chk("lone one", n, c[0]);
    chk("own setting", 1, c[1]);
    chk("lone zero", n, c[2]);
    chk("long runs", 4, c[3]);
  endtask : t_isi

  task automatic t_gear;
    int k;
    int r;
    logic pa_l, pb_l;
    r = 0;
    @(posedge clk_i);
    core_oe <= 1'b0;
    @(negedge clk_i);
    pa_l = pa;
    pb_l = pb;
    for (k = 0; k < 16; k++) begin
      @(negedge clk_i);
      // Second flop still holds the old enable until the next gear step
      if (k == 0) chk("oe x2 held", 1'b1, pad_oe);
      r += (pa && !pa_l);
      chk("phase b leads a", pb_l, pa);
      pa_l = pa;
      pb_l = pb;
    end
    chk("phase a rises", 4, r);
    chk("oe x2", 1'b0, pad_oe);
  endtask : t_gear

  // Lag of the write strobe behind phase a, modulo the gear period
  task automatic lag(output int d);
    logic [7:0] a, w;
    int i;
    for (i = 0; i < 8; i++) begin
      @(negedge clk_i);
      a[i] = pa;
      w[i] = wsc;
    end
    d = 9;
    for (i = 3; i >= 0; i--) if (w[7:4] === a[(7-i) -: 4]) d = i;
  endtask : lag

  task automatic t_wlvl;
    int l0, l, k;
    wb(1'b1, dsio_pkg::ADDR_WLVL, 32'h0);
    repeat (20) @(posedge clk_i);
    lag(l0);
    for (k = 0; k < 4; k++) begin
      @(posedge clk_i);
      code <= codes[k];
      wb(1'b1, dsio_pkg::ADDR_WLVL, {24'h0, wls[k]});
      repeat (20) @(posedge clk_i);
      lag(l);
      chk("wlvl lag", (l0 + offs[k]) % 4, l);
    end
  endtask : t_wlvl

  task automatic t_read(input logic req, input logic x2);
    int k, r;
    logic p0, l0, s_l;
    r = 0;
    if (req) begin
      @(posedge clk_i);
      rd <= 1'b1;
      @(posedge clk_i);
      rd <= 1'b0;
    end
    p0 = pol;
    l0 = lat;
    s_l = srs[0];
    fork
      mem.burst(4);
      for (k = 0; k < 70; k++) begin
        @(negedge clk_i);
        if (k == 10) chk("preamble low", 1'b0, pd);
        chk("fanout", {11{srs[0]}}, srs);
        r += (srs[0] && !s_l);
        s_l = srs[0];
      end
    join
    // Four toggles plus the rise when the released line floats back high
    chk("read strobe rises", 5, r);
    chk("floating high", 1'b1, pd);
    wb(1'b0, dsio_pkg::ADDR_STATUS, 32'h0);
    chk("tracker idle", 2'h0, rdat[5:4]);
    chk("polarity", pol, rdat[1]);
    chk("latch", lat, rdat[2]);
    if (!x2) chk("no latch", 1'b0, lat);
    if (!req) chk("hold pol", p0, pol);
    if (!req) chk("hold lat", l0, lat);
  endtask : t_read

  // Main sequence
  initial begin
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    chk("rst oe", 1'b0, pad_oe);
    chk("rst pd", 1'b1, pd);
    chk("rst pol", 1'b0, pol);
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_oe_sdr();
    t_isi(1'b0, 1);
    // Setting 3 repeats the lone bit three times after its own cycle
    t_isi(1'b1, 4);
    t_gear();
    t_wlvl();
    t_read(1'b1, 1'b1);
    wb(1'b1, dsio_pkg::ADDR_CTRL, 32'h0);
    t_read(1'b1, 1'b0);
    t_read(1'b0, 1'b0);
    wrap_up();
  end

  // Hang guard, well beyond the few hundred cycles the sequence needs
  initial begin
    #3000000;
    n_fail++;
    wrap_up();
  end
endmodule : dsio_strobe_ctrl_test
